// ===== dv/sirc_remote_sensor_model.sv
// Behavioural remote isolated sensors on the three link pins.
`timescale 1ns/10ps
module sirc_remote_sensor_model #(
  parameter int          SAMPLE_W = 8,
  parameter int          LAG      = 0,
  parameter logic [31:0] PAT      = 32'h0000_0000
) (
  input  wire logic       i_clk_sys,
  input  wire logic [2:0] i_link_out,
  input  wire logic [2:0] i_link_oe,
  output logic      [2:0] o_link_in
);
  // ****************************************************************
  // Each request returns PAT plus the pair index, MSB first; an idle line toggles.
  // ****************************************************************
  logic [31:0] sh_q [3];
  int          cnt_q [3];
  initial o_link_in = 3'h0;
  always @(posedge i_clk_sys)
  begin
    for (int p = 0; p < 3; p++)
    begin
      if (i_link_oe[p] && i_link_out[p])
      begin
        sh_q[p] = PAT + 32'(p);
        cnt_q[p] = SAMPLE_W + LAG;
      end
      if (cnt_q[p] > 0 && cnt_q[p] <= SAMPLE_W)
      begin
        o_link_in[p] <= sh_q[p][SAMPLE_W-1];
        sh_q[p] = sh_q[p] << 1;
      end
      else
        o_link_in[p] <= ~o_link_in[p];
      if (cnt_q[p] > 0)
        cnt_q[p]--;
    end
  end
endmodule : sirc_remote_sensor_model

// ===== dv/sirc_routing_checker.sv
// Port assertions for the sensor routing control.
`timescale 1ns/10ps
module sirc_routing_checker
  import sirc_pkg::*;
#(
  parameter int SAMPLE_W = SIRC_SAMPLE_W
) (
  input wire logic                         i_clk_sys,
  input wire logic                         i_resetn,
  input wire logic                         i_psel,
  input wire logic                         i_penable,
  input wire logic                         i_pwrite,
  input wire logic [SIRC_ADDR_W-1:0]       i_paddr,
  input wire logic [31:0]                  o_prdata,
  input wire logic                         o_pready,
  input wire logic                         o_pslverr,
  input wire logic [3:0]                   o_pair_diff,
  input wire logic [SIRC_REMOTE_PAIRS-1:0] o_remote_pair_enable,
  input wire logic [SIRC_REMOTE_PAIRS-1:0] o_link_out,
  input wire logic [SIRC_REMOTE_PAIRS-1:0] o_link_oe,
  input wire logic                         o_ram_valid,
  input wire logic                         i_ram_ready,
  input wire logic [SIRC_RAM_ADDR_W-1:0]   o_ram_addr,
  input wire logic [SIRC_RAM_DATA_W-1:0]   o_ram_data
);
  // ****************************************************************
  // Bus, link and sample store relations.
  // ****************************************************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  wire acc = i_psel && i_penable;
  sequence s_stall; o_ram_valid && !i_ram_ready; endsequence
  sequence s_link_req; o_link_oe != 3'h0; endsequence
  sequence s_link_quiet; (o_link_oe == 3'h0) [*8]; endsequence
  AST_LINK_ONE_REQ: assert property (s_link_req |=> s_link_quiet)
    else $error("link request longer than one cycle or repeated during capture");
  AST_LINK_ENABLED: assert property (s_link_req |-> (o_link_oe & ~o_remote_pair_enable) == 3'h0)
    else $error("link request on a pair that is not remote");
  AST_LINK_DRIVE: assert property (s_link_req |-> o_link_out == o_link_oe)
    else $error("link request level differs from its enable");
  AST_ALL_LOCAL: assert property (o_remote_pair_enable == 3'h0 |-> o_link_oe == 3'h0)
    else $error("link driven with every pair local");
  AST_RAM_HOLD: assert property (s_stall |=> o_ram_valid && $stable(o_ram_addr) && $stable(o_ram_data))
    else $error("sample word changed while stalled");
  AST_RAM_ADDR: assert property (o_ram_valid |-> (o_ram_addr < 8'h0B || o_ram_addr inside {[8'h10:8'h12]}))
    else $error("sample word at an address outside the slot and remote areas");
  AST_RAM_WIDTH: assert property (o_ram_valid |-> (o_ram_data >> SAMPLE_W) == 32'h0)
    else $error("sample word wider than a sample");
  AST_PREADY: assert property (o_pready)
    else $error("bus slave inserted a wait state");
  AST_SLVERR_GATE: assert property (o_pslverr |-> acc)
    else $error("bus error outside the access phase");
  AST_ERR_READ_ZERO: assert property (acc && !i_pwrite && o_pslverr |-> o_prdata == 32'h0)
    else $error("refused read returned data");
  AST_READ_UPPER: assert property (acc && !i_pwrite && i_paddr != {SIRC_STATUS_IDX, 2'b00} |-> o_prdata[31:8] == 24'h0)
    else $error("register read has upper bits set");
  AST_RESET_QUIET: assert property ($rose(i_resetn) |-> !o_ram_valid && o_link_oe == 3'h0 && o_pair_diff == 4'h0)
    else $error("outputs active right after reset");
endmodule : sirc_routing_checker

// ===== dv/sirc_routing_ctrl_bench.sv
// Self-checking bench for the sensor routing control.
`timescale 1ns/10ps
module sirc_routing_ctrl_bench;
  import sirc_pkg::*;
  localparam int FL = 8;
  localparam int SW = 8;
  localparam logic [31:0] RPAT = 32'h0000_00C5;
  localparam logic [7:0] DIF [2] = '{8'h50, 8'hF0};
  localparam logic [7:0] PRE [2] = '{8'h20, 8'h00};
  localparam logic [7:0] RMT [2] = '{8'h28, 8'h00};
  localparam logic [3:0] NS [2] = '{4'h6, 4'hB};
  localparam logic MOD [2] = '{1'b1, 1'b0};
  logic i_clk_sys = 1'b0, i_resetn = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_mod_bit = 1'b0, i_ram_ready = 1'b0;
  logic [17:0] i_paddr = 18'h0;
  logic [31:0] i_pwdata = 32'h0, o_prdata, o_ram_data;
  logic o_pready, o_pslverr, o_preamp_gain8, o_ram_valid;
  logic [3:0] o_mux_source, o_pair_diff;
  logic [2:0] o_remote_pair_enable, i_link_in, o_link_out, o_link_oe;
  logic [7:0] o_ram_addr;
  logic [32:0] qa [$];
  logic [39:0] ql [$], qr [$];
  int errors = 0, checked = 0, nloc = 0, cyc = 0;
  bit no_rmt = 1'b0;
  sirc_routing_ctrl #(.FIR_LEN(FL), .SAMPLE_W(SW)) u_sirc_routing_ctrl (.*);
  sirc_remote_sensor_model #(.SAMPLE_W(SW), .LAG(0), .PAT(RPAT)) u_sirc_remote_sensor_model
  (
    .i_clk_sys  (i_clk_sys),
    .i_link_out (o_link_out),
    .i_link_oe  (o_link_oe),
    .o_link_in  (i_link_in)
  );
  initial
  begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  // ****************************************************************
  // Bus, compare and closing tasks.
  // ****************************************************************
  task automatic chk_val(input logic [39:0] g, input logic [39:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_val
  task automatic chk_word(input logic [39:0] g, input logic [39:0] e);
    chk_val(g, e);
  endtask : chk_word
  task automatic test_done;
    $display("Counts: checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [32:0] e);
    qa.push_back(e);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    do
      @(posedge i_clk_sys);
    while (o_pready !== 1'b1);
  endtask : apb
  task automatic idle(input int n);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    repeat (n) @(posedge i_clk_sys);
  endtask : idle
  // ****************************************************************
  // Output watcher, stalling consumer and cycle limit.
  // ****************************************************************
  always @(posedge i_clk_sys)
  begin
    i_ram_ready <= ($urandom_range(3) != 0);
    cyc++;
    if (cyc > 5000)
    begin
      errors++;
      test_done();
    end
    if (i_psel && i_penable && o_pready === 1'b1 && qa.size() > 0)
      chk_val({o_pslverr, i_pwrite ? 32'h0 : o_prdata}, qa.pop_front());
    if (o_ram_valid === 1'b1 && i_ram_ready)
      if (o_ram_addr < 8'h10)
      begin
        nloc++;
        if (ql.size() > 0)
          chk_word({o_ram_addr, o_ram_data}, ql.pop_front());
      end
      else if (no_rmt || qr.size() > 0)
        chk_word({o_ram_addr, o_ram_data}, no_rmt ? 40'h0 : qr.pop_front());
  end
  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial
  begin
    logic [31:0] v;
    logic [7:0]  cfg, old;
    old = 8'h00;
    repeat (3) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    @(posedge i_clk_sys);
    void'($urandom(32'hCA76));
    apb(0, {SIRC_PAIR_MODE_IDX, 2'b00}, 0, 0);
    apb(0, {SIRC_PREAMP_IDX, 2'b00}, 0, 0);
    apb(0, {SIRC_REMOTE_IDX, 2'b00}, 0, 0);
    idle(1);
    chk_val({o_pair_diff, o_preamp_gain8, o_remote_pair_enable}, 0);
    $display("Test reset values done");
    for (int r = 1; r < SIRC_SLOT_REGS; r++)
    begin
      v = $urandom;
      apb(1, {16'(SIRC_SLOT_CFG0_IDX + r), 2'b00}, v, 0);
      apb(0, {16'(SIRC_SLOT_CFG0_IDX + r), 2'b00}, 0, {25'h0, v[7:0]});
    end
    apb(1, {16'h2106, 2'b00}, 32'hFF, {1'b1, 32'h0});
    apb(0, {16'h2106, 2'b00}, 0, {1'b1, 32'h0});
    apb(0, {SIRC_PREAMP_IDX, 2'b01}, 0, {1'b1, 32'h0});
    idle(1);
    $display("Test register access done");
    for (int c = 0; c < 2; c++)
    begin
      cfg = {DIF[c][7:4], PRE[c][5], RMT[c][5:3]};
      apb(1, {SIRC_SLOT_CFG0_IDX, 2'b00}, 0, 0);
      apb(1, {SIRC_PAIR_MODE_IDX, 2'b00}, DIF[c], 0);
      apb(1, {SIRC_PREAMP_IDX, 2'b00}, PRE[c], 0);
      apb(1, {SIRC_REMOTE_IDX, 2'b00}, RMT[c], 0);
      apb(0, {SIRC_REMOTE_IDX, 2'b00}, 0, {25'h0, RMT[c]});
      idle(3);
      chk_val({o_pair_diff, o_preamp_gain8, o_remote_pair_enable}, old);
      no_rmt = (RMT[c] == 8'h00);
      i_mod_bit <= MOD[c];
      for (int s = 0; s < NS[c]; s++)
        ql.push_back({8'(s), 32'(FL * MOD[c])});
      for (int p = 0; p < 3; p++)
        if (RMT[c][3 + p])
          qr.push_back({8'h10 + 8'(p), RPAT + 32'(p)});
      nloc = 0;
      apb(1, {SIRC_SLOT_CFG0_IDX, 2'b00}, {NS[c], 4'h0}, 0);
      idle(4);
      chk_val(o_mux_source, v[3:0]);
      chk_val({o_pair_diff, o_preamp_gain8, o_remote_pair_enable}, cfg);
      for (int k = 0; k < 2000 && nloc < NS[c] - 1; k++)
        @(posedge i_clk_sys);
      apb(1, {SIRC_SLOT_CFG0_IDX, 2'b00}, 0, 0);
      idle(1);
      for (int k = 0; k < 2000 && ql.size() + qr.size() > 0; k++)
        @(posedge i_clk_sys);
      chk_val(ql.size() + qr.size(), 0);
      idle(80);
      old = cfg;
      $display("Test frame config %0d done", c);
    end
    test_done();
  end
endmodule : sirc_routing_ctrl_bench
bind sirc_routing_ctrl sirc_routing_checker #(.SAMPLE_W(SAMPLE_W)) u_sirc_routing_checker (.*);

// ===== rtl/sirc_pair_buf.sv
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/10ps
module sirc_pair_buf #(
  parameter int W = 40
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_resetn,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic [W-1:0]      o_out_data
);

  typedef struct packed {
    logic [1:0][W-1:0] mem;
    logic              wr_ptr;
    logic              rd_ptr;
    logic [1:0]        count;
  } sirc_buf_type;

  sirc_buf_type buf_q;
  sirc_buf_type buf_d;
  logic         push;
  logic         pop;

  assign o_in_ready  = (buf_q.count != 2'd2);
  assign o_out_valid = (buf_q.count != 2'd0);
  assign o_out_data  = buf_q.mem[buf_q.rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb
  begin
    buf_d = buf_q;
    if (push)
    begin
      buf_d.mem[buf_q.wr_ptr] = i_in_data;
      buf_d.wr_ptr            = ~buf_q.wr_ptr;
    end
    if (pop)
    begin
      buf_d.rd_ptr = ~buf_q.rd_ptr;
    end
    if (push && !pop)
    begin
      buf_d.count = buf_q.count + 2'd1;
    end
    else if (pop && !push)
    begin
      buf_d.count = buf_q.count - 2'd1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      buf_q <= '0;
    end
    else
    begin
      buf_q <= buf_d;
    end
  end

endmodule : sirc_pair_buf

// ===== rtl/sirc_pkg.sv
// Package with register map, field positions, reset values and states of the sensor routing control.
package sirc_pkg;

  // ****************************************************************
  // Register indices; the byte address is four times the index.
  // ****************************************************************
  localparam logic [15:0] SIRC_SLOT_CFG0_IDX   = 16'h2100;
  localparam logic [15:0] SIRC_SLOT_CFG5_IDX   = 16'h2105;
  localparam logic [15:0] SIRC_PAIR_MODE_IDX   = 16'h210C;
  localparam logic [15:0] SIRC_PREAMP_IDX      = 16'h2704;
  localparam logic [15:0] SIRC_REMOTE_IDX      = 16'h2709;
  localparam logic [15:0] SIRC_STATUS_IDX      = 16'h2710;
  localparam int          SIRC_ADDR_W          = 18;

  // ****************************************************************
  // Field positions and reset values.
  // ****************************************************************
  localparam int          SIRC_DIFF_LSB        = 4;
  localparam int          SIRC_PREAMP_BIT      = 5;
  localparam int          SIRC_REMOTE_LSB      = 3;
  localparam int          SIRC_COUNT_LSB       = 4;
  localparam logic [7:0]  SIRC_CFG_RESET       = 8'h00;
  localparam int          SIRC_NUM_SLOTS       = 11;
  localparam int          SIRC_SLOT_REGS       = 6;
  localparam int          SIRC_REMOTE_PAIRS    = 3;

  // ****************************************************************
  // Sample store layout and timing counts.
  // ****************************************************************
  localparam int          SIRC_RAM_ADDR_W      = 8;
  localparam int          SIRC_RAM_DATA_W      = 32;
  localparam logic [7:0]  SIRC_RMT_BASE        = 8'h10;
  localparam int          SIRC_FIR_LEN         = 288;
  localparam int          SIRC_SAMPLE_W        = 22;

  typedef enum logic [1:0]
  {
    SIRC_IDLE    = 2'b00,
    SIRC_START   = 2'b01,
    SIRC_CONVERT = 2'b11,
    SIRC_WRITE   = 2'b10
  } sirc_state_type;

endpackage : sirc_pkg

// ===== rtl/sirc_routing_ctrl.sv
// Sensor input routing control: register file, slot sequencer, decimator and remote sensor capture.
// Operation
// - Local inputs go one after another through the multiplexer into one shared converter.
// - The converter bitstream is decimated by a FIR and written to compute RAM.
// - Remote pair samples bypass the multiplexer and go straight to compute RAM.
// - Eleven 4-bit slot source selects, written by software, set the sampling order.
// - Eight current pins act as single-ended inputs or four differential pairs.
// - Pair-0 differential bit at index 0x210C bit 4 selects pair-0 mode.
// - Preamp bit at index 0x2704 bit 5 gives pair-0 gain 8, else gain 1.
// - Remote enable bits at index 0x2709 bits 5..3 turn pairs 1-3 into remote links.
// - A cleared remote enable keeps its pair as a local multiplexed analog input.
// - Pair 0 has no remote option and is always a local input.
// - Each remote sensor link is a two-way serial stream carrying its samples.
// - With no remote pair enabled every channel runs through the shared converter.
// - Remote bit 3 is pair 1, bit 4 is pair 2, bit 5 is pair 3.
// - A frame starts at slot 0 and runs for the frame slot count of slots.
`timescale 1ns/10ps
module sirc_routing_ctrl
  import sirc_pkg::*;
#(
  parameter int FIR_LEN  = SIRC_FIR_LEN,
  parameter int SAMPLE_W = SIRC_SAMPLE_W
) (
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_resetn,
  input  wire logic                          i_psel,
  input  wire logic                          i_penable,
  input  wire logic                          i_pwrite,
  input  wire logic [SIRC_ADDR_W-1:0]        i_paddr,
  input  wire logic [31:0]                   i_pwdata,
  output logic [31:0]                        o_prdata,
  output logic                               o_pready,
  output logic                               o_pslverr,
  input  wire logic                          i_mod_bit,
  output logic [3:0]                         o_mux_source,
  output logic [3:0]                         o_pair_diff,
  output logic                               o_preamp_gain8,
  output logic [SIRC_REMOTE_PAIRS-1:0]       o_remote_pair_enable,
  input  wire logic [SIRC_REMOTE_PAIRS-1:0]  i_link_in,
  output logic [SIRC_REMOTE_PAIRS-1:0]       o_link_out,
  output logic [SIRC_REMOTE_PAIRS-1:0]       o_link_oe,
  output logic                               o_ram_valid,
  input  wire logic                          i_ram_ready,
  output logic [SIRC_RAM_ADDR_W-1:0]         o_ram_addr,
  output logic [SIRC_RAM_DATA_W-1:0]         o_ram_data
);

  // ****************************************************************
  // State.
  // ****************************************************************
  localparam int CNT_W = $clog2(FIR_LEN);
  localparam int RX_W  = $clog2(SAMPLE_W + 2);
  localparam int BUF_W = SIRC_RAM_ADDR_W + SIRC_RAM_DATA_W;
  localparam int RP    = SIRC_REMOTE_PAIRS;

  typedef struct packed {
    sirc_state_type                    state;
    logic [SIRC_SLOT_REGS-1:0][7:0]    slot_cfg;
    logic [7:0]                        pair_mode;
    logic [7:0]                        preamp;
    logic [7:0]                        remote;
    logic [3:0]                        act_diff;
    logic                              act_gain8;
    logic [RP-1:0]                     act_remote;
    logic [3:0]                        slot;
    logic [CNT_W-1:0]                  bit_cnt;
    logic [SAMPLE_W-1:0]               acc;
    logic                              mod_s1;
    logic                              mod_s2;
    logic [RP-1:0]                     link_s1;
    logic [RP-1:0]                     link_s2;
    logic                              rx_busy;
    logic [RX_W-1:0]                   rx_cnt;
    logic [RP-1:0][SAMPLE_W-1:0]       rx_shift;
    logic [RP-1:0][SAMPLE_W-1:0]       rmt_data;
    logic [RP-1:0]                     rmt_pend;
    logic [RP-1:0]                     link_out;
    logic [RP-1:0]                     link_oe;
    logic [31:0]                       prdata;
    logic                              pslverr;
  } sirc_ctrl_type;

  sirc_ctrl_type          ctl_q;
  sirc_ctrl_type          ctl_d;
  logic                   push_valid;
  logic                   push_ready;
  logic [BUF_W-1:0]       push_word;
  logic [BUF_W-1:0]       pop_word;
  logic [3:0]             frame_slots;
  logic [RP-1:0]          rmt_clear;
  logic                   wr_en;
  logic                   setup;

  assign frame_slots = ctl_q.slot_cfg[0][SIRC_COUNT_LSB +: 4];
  assign wr_en       = i_psel && i_penable && i_pwrite;
  assign setup       = i_psel && !i_penable;

  // ****************************************************************
  // Slot source lookup: slot 0 sits in the low nibble of the last register.
  // ****************************************************************
  function automatic logic [3:0] slot_source(input logic [SIRC_SLOT_REGS-1:0][7:0] cfg,
                                             input logic [3:0] s);
    logic [2:0] r;
    r = 3'(SIRC_SLOT_REGS - 1) - s[3:1];
    return s[0] ? cfg[r][7:4] : cfg[r][3:0];
  endfunction : slot_source

  // ****************************************************************
  // Write arbitration into the sample buffer; the local sample goes first.
  // ****************************************************************
  always_comb
  begin
    push_valid = 1'b0;
    push_word  = '0;
    rmt_clear  = '0;
    if (ctl_q.state == SIRC_WRITE)
    begin
      push_valid = 1'b1;
      push_word  = {8'(ctl_q.slot), 32'(ctl_q.acc)};
    end
    else
    begin
      for (int p = RP - 1; p >= 0; p--)
      begin
        if (ctl_q.rmt_pend[p])
        begin
          push_valid   = 1'b1;
          push_word    = {8'(SIRC_RMT_BASE + 8'(p)), 32'(ctl_q.rmt_data[p])};
          rmt_clear    = '0;
          rmt_clear[p] = push_ready;
        end
      end
    end
  end

  // ****************************************************************
  // Next state.
  // ****************************************************************
  always_comb
  begin
    ctl_d         = ctl_q;
    ctl_d.mod_s1  = i_mod_bit;
    ctl_d.mod_s2  = ctl_q.mod_s1;
    ctl_d.link_s1 = i_link_in;
    ctl_d.link_s2 = ctl_q.link_s1;
    ctl_d.link_out = '0;
    ctl_d.link_oe  = '0;

    // APB: read data is caught in the setup cycle, writes land in the access cycle.
    if (setup)
    begin
      ctl_d.prdata  = 32'h0000_0000;
      ctl_d.pslverr = 1'b0;
      if (i_paddr[1:0] != 2'b00)
      begin
        ctl_d.pslverr = 1'b1;
      end
      else if ((i_paddr[SIRC_ADDR_W-1:2] >= SIRC_SLOT_CFG0_IDX) &&
               (i_paddr[SIRC_ADDR_W-1:2] <= SIRC_SLOT_CFG5_IDX))
      begin
        ctl_d.prdata[7:0] = ctl_q.slot_cfg[3'(i_paddr[4:2])];
      end
      else if (i_paddr[SIRC_ADDR_W-1:2] == SIRC_PAIR_MODE_IDX)
      begin
        ctl_d.prdata[7:0] = ctl_q.pair_mode;
      end
      else if (i_paddr[SIRC_ADDR_W-1:2] == SIRC_PREAMP_IDX)
      begin
        ctl_d.prdata[7:0] = ctl_q.preamp;
      end
      else if (i_paddr[SIRC_ADDR_W-1:2] == SIRC_REMOTE_IDX)
      begin
        ctl_d.prdata[7:0] = ctl_q.remote;
      end
      else if (i_paddr[SIRC_ADDR_W-1:2] == SIRC_STATUS_IDX)
      begin
        ctl_d.prdata[15:0] = {2'b00, ctl_q.state, ctl_q.rx_busy, ctl_q.rmt_pend, ctl_q.slot,
                              ctl_q.act_gain8, ctl_q.act_remote};
        ctl_d.prdata[19:16] = ctl_q.act_diff;
      end
      else
      begin
        ctl_d.pslverr = 1'b1;
      end
    end

    if (wr_en && (i_paddr[1:0] == 2'b00))
    begin
      if ((i_paddr[SIRC_ADDR_W-1:2] >= SIRC_SLOT_CFG0_IDX) &&
          (i_paddr[SIRC_ADDR_W-1:2] <= SIRC_SLOT_CFG5_IDX))
      begin
        ctl_d.slot_cfg[3'(i_paddr[4:2])] = i_pwdata[7:0];
      end
      else if (i_paddr[SIRC_ADDR_W-1:2] == SIRC_PAIR_MODE_IDX)
      begin
        ctl_d.pair_mode = i_pwdata[7:0];
      end
      else if (i_paddr[SIRC_ADDR_W-1:2] == SIRC_PREAMP_IDX)
      begin
        ctl_d.preamp = i_pwdata[7:0];
      end
      else if (i_paddr[SIRC_ADDR_W-1:2] == SIRC_REMOTE_IDX)
      begin
        ctl_d.remote = i_pwdata[7:0];
      end
    end

    // Slot sequencer with shared boxcar FIR decimator.
    case (ctl_q.state)
      SIRC_IDLE:
      begin
        if (frame_slots != 4'h0)
        begin
          ctl_d.state = SIRC_START;
        end
      end
      SIRC_START:
      begin
        ctl_d.act_diff   = ctl_q.pair_mode[SIRC_DIFF_LSB +: 4];
        ctl_d.act_gain8  = ctl_q.preamp[SIRC_PREAMP_BIT];
        ctl_d.act_remote = ctl_q.remote[SIRC_REMOTE_LSB +: RP];
        ctl_d.slot       = 4'h0;
        ctl_d.bit_cnt    = '0;
        ctl_d.acc        = '0;
        ctl_d.state      = SIRC_CONVERT;
        if (!ctl_q.rx_busy)
        begin
          ctl_d.link_out = ctl_q.remote[SIRC_REMOTE_LSB +: RP];
          ctl_d.link_oe  = ctl_q.remote[SIRC_REMOTE_LSB +: RP];
          ctl_d.rx_busy  = |ctl_q.remote[SIRC_REMOTE_LSB +: RP];
          ctl_d.rx_cnt   = '0;
        end
      end
      SIRC_CONVERT:
      begin
        ctl_d.acc     = ctl_q.acc + SAMPLE_W'(ctl_q.mod_s2);
        ctl_d.bit_cnt = ctl_q.bit_cnt + CNT_W'(1);
        if (ctl_q.bit_cnt == CNT_W'(FIR_LEN - 1))
        begin
          ctl_d.state = SIRC_WRITE;
        end
      end
      SIRC_WRITE:
      begin
        if (push_ready)
        begin
          ctl_d.bit_cnt = '0;
          ctl_d.acc     = '0;
          if ((frame_slots == 4'h0) || (ctl_q.slot >= frame_slots - 4'h1))
          begin
            ctl_d.state = (frame_slots != 4'h0) ? SIRC_START : SIRC_IDLE;
          end
          else
          begin
            ctl_d.slot  = ctl_q.slot + 4'h1;
            ctl_d.state = SIRC_CONVERT;
          end
        end
      end
      default:
      begin
        ctl_d.state = SIRC_IDLE;
      end
    endcase

    // Remote capture: sample bits follow the request pulse, most significant first.
    if (ctl_q.rx_busy && (ctl_q.state != SIRC_START || ctl_q.rx_busy))
    begin
      if (ctl_q.link_oe == '0)
      begin
        for (int p = 0; p < RP; p++)
        begin
          ctl_d.rx_shift[p] = {ctl_q.rx_shift[p][SAMPLE_W-2:0], ctl_q.link_s2[p]};
        end
        // Two extra shifts cover the synchroniser delay, so the last bits held are the sample.
        ctl_d.rx_cnt = ctl_q.rx_cnt + RX_W'(1);
        if (ctl_q.rx_cnt == RX_W'(SAMPLE_W + 1))
        begin
          ctl_d.rx_busy = 1'b0;
        end
      end
    end

    // A finished capture sets its pending flag even in the cycle it is cleared.
    ctl_d.rmt_pend = ctl_q.rmt_pend & ~rmt_clear;
    if (ctl_q.rx_busy && !ctl_d.rx_busy)
    begin
      for (int p = 0; p < RP; p++)
      begin
        if (ctl_q.act_remote[p])
        begin
          ctl_d.rmt_data[p] = ctl_d.rx_shift[p];
          ctl_d.rmt_pend[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ctl_q           <= '0;
      ctl_q.state     <= SIRC_IDLE;
      ctl_q.pair_mode <= SIRC_CFG_RESET;
      ctl_q.preamp    <= SIRC_CFG_RESET;
      ctl_q.remote    <= SIRC_CFG_RESET;
    end
    else
    begin
      ctl_q <= ctl_d;
    end
  end

  // ****************************************************************
  // Sample buffer towards compute RAM.
  // ****************************************************************
  sirc_pair_buf #(
    .W (BUF_W)
  ) u_sirc_pair_buf (
    .i_clk_sys   (i_clk_sys),
    .i_resetn    (i_resetn),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (push_word),
    .o_out_valid (o_ram_valid),
    .i_out_ready (i_ram_ready),
    .o_out_data  (pop_word)
  );

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign o_ram_addr           = pop_word[BUF_W-1:SIRC_RAM_DATA_W];
  assign o_ram_data           = pop_word[SIRC_RAM_DATA_W-1:0];
  assign o_prdata             = ctl_q.prdata;
  assign o_pslverr            = ctl_q.pslverr && i_psel && i_penable;
  assign o_pready             = 1'b1;
  assign o_mux_source         = slot_source(ctl_q.slot_cfg, ctl_q.slot);
  assign o_pair_diff          = ctl_q.act_diff;
  assign o_preamp_gain8       = ctl_q.act_gain8;
  assign o_remote_pair_enable = ctl_q.act_remote;
  assign o_link_out           = ctl_q.link_out;
  assign o_link_oe            = ctl_q.link_oe;

endmodule : sirc_routing_ctrl
